// ==== include/gpfgh_pkg.sv ====
// Constants and carrier types for the general-purpose ports F, G and H.
// Assumes a byte-wide CPU register map behind an Avalon-MM slave, 32-bit words.
package gpfgh_pkg;

    // Printed offsets are not multiples of four: they are word indices
    localparam logic [7:0] IDX_F_DATA  = 8'h09;
    localparam logic [7:0] IDX_G_DATA  = 8'h0A;
    localparam logic [7:0] IDX_H_DATA  = 8'h0B;
    localparam logic [7:0] IDX_F_DIR   = 8'h0C;
    localparam logic [7:0] IDX_G_DIR   = 8'h0D;
    localparam logic [7:0] IDX_H_DIR   = 8'h0E;
    localparam logic [7:0] IDX_KBD_EN  = 8'h0F;

    localparam int F_WIDTH = 8;
    localparam int G_WIDTH = 3;
    localparam int H_WIDTH = 2;
    localparam int KBD_LO  = 3;

    localparam logic [7:0] DIR_RST     = 8'h00;
    localparam logic [7:0] KBD_EN_RST  = 8'h00;
    localparam logic [31:0] UNMAPPED_RD = 32'h0000_0000;

    // Byte address of a register from its index
    function automatic logic [9:0] reg_addr(input logic [7:0] idx);
        reg_addr = {idx, 2'b00};
    endfunction

    typedef struct packed {
        logic [9:0]  address;
        logic        read;
        logic        write;
        logic [3:0]  byteenable;
        logic [31:0] writedata;
    } gpfgh_req_s;

    typedef struct packed {
        logic [31:0] readdata;
        logic        waitrequest;
    } gpfgh_rsp_s;

endpackage

// ==== hdl/gpfgh_port.sv ====
// One parallel port: latch, direction, pin synchroniser, read mux.
// Assumes pin inputs asynchronous to clk; clk is the system bus clock.
module gpfgh_port #(
    parameter int W        = 8,
    parameter bit DIR_RSTS = 1'b1
) (
    // Clock and reset
    input  wire logic         clk,
    input  wire logic         rst,
    // Register side
    input  wire logic         dat_we,
    input  wire logic         dir_we,
    input  wire logic [W-1:0] wdata,
    output logic      [W-1:0] dat_rd,
    output logic      [W-1:0] dir_q,
    output logic      [W-1:0] pin_sync,
    // Pins
    input  wire logic [W-1:0] pin_in,
    output logic      [W-1:0] pin_out,
    output logic      [W-1:0] pin_oe_n
);
    logic [W-1:0] latch_r;
    logic [W-1:0] dir_r;
    logic [W-1:0] meta_r;
    logic [W-1:0] sync_r;

    always_ff @(posedge clk) begin
        if (dat_we) begin
            latch_r <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        if (rst && DIR_RSTS) begin
            dir_r <= '0;
        end else if (dir_we) begin
            dir_r <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        meta_r <= pin_in;
        sync_r <= meta_r;
    end

    assign dat_rd   = (dir_r & latch_r) | (~dir_r & sync_r);
    assign pin_out  = latch_r;
    assign pin_oe_n = ~dir_r;
    assign dir_q    = dir_r;
    assign pin_sync = sync_r;

    a_dir_reset: assert property (@(posedge clk) rst |=> dir_r == '0 || !DIR_RSTS)
        else $error("direction not cleared by reset");
    a_read_pin: assert property (@(posedge clk) disable iff (rst)
        ##2 (dir_r == '0) |-> dat_rd == $past(pin_in, 2))
        else $error("input read differs from pin");
    a_read_latch: assert property (@(posedge clk) disable iff (rst)
        (dat_we && !dir_we) |=> ((dat_rd ^ $past(wdata)) & dir_r) == '0)
        else $error("output read differs from latch");
    a_drive_en: assert property (@(posedge clk) disable iff (rst)
        dir_we |=> pin_oe_n == ~$past(wdata))
        else $error("output enable does not follow direction");
    a_write_any: assert property (@(posedge clk) disable iff (rst)
        dat_we |=> pin_out == $past(wdata))
        else $error("latch write lost");
endmodule // gpfgh_port

// ==== hdl/gpfgh_ports.sv ====
// Ports F, G and H with keypad interrupt pin hand-off, Avalon-MM slave.
// Assumes a word-addressed register map; register index times four gives
// the byte address. Single clock, synchronous active-high reset.
//
// Register access over Avalon-MM was left to the implementer.
module gpfgh_ports
    import gpfgh_pkg::*;
(
    // Clock and reset
    input  wire logic                 clk,
    input  wire logic                 rst,
    // Avalon-MM slave
    input  wire logic [9:0]           avs_address,
    input  wire logic                 avs_read,
    input  wire logic                 avs_write,
    input  wire logic [3:0]           avs_byteenable,
    input  wire logic [31:0]          avs_writedata,
    output logic      [31:0]          avs_readdata,
    output logic                      avs_waitrequest,
    // Port F pins
    input  wire logic [7:0]           f_pin_in,
    output logic      [7:0]           f_pin_out,
    output logic      [7:0]           f_pin_oe_n,
    // Port G pins
    input  wire logic [2:0]           g_pin_in,
    output logic      [2:0]           g_pin_out,
    output logic      [2:0]           g_pin_oe_n,
    // Port H pins
    input  wire logic [1:0]           h_pin_in,
    output logic      [1:0]           h_pin_out,
    output logic      [1:0]           h_pin_oe_n,
    // Keypad interrupt module side
    output logic      [1:0]           keypad_irq_pins,
    output logic      [1:0]           keypad_irq_enable_bits
);
    import gpfgh_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Bus handshake: one wait cycle so read data comes from a flop
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,
        ST_DONE = 2'b01
    } gpfgh_bus_e;

    gpfgh_bus_e  st_r;
    gpfgh_bus_e  st_nxt;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic [1:0]  kbd_en_r;

    wire        req      = avs_read | avs_write;
    wire        take     = req && (st_r == ST_DONE);
    wire        wr_ok    = avs_write && take && avs_byteenable[0];
    wire [7:0]  idx      = avs_address[9:2];
    wire [7:0]  wb       = avs_writedata[7:0];

    wire hit_f_dat = (idx == IDX_F_DATA);
    wire hit_g_dat = (idx == IDX_G_DATA);
    wire hit_h_dat = (idx == IDX_H_DATA);
    wire hit_f_dir = (idx == IDX_F_DIR);
    wire hit_g_dir = (idx == IDX_G_DIR);
    wire hit_h_dir = (idx == IDX_H_DIR);
    wire hit_kbd   = (idx == IDX_KBD_EN);

    // Per-register write strobes; writes without lane 0 are dropped
    wire wr_f_dat  = wr_ok && hit_f_dat;
    wire wr_g_dat  = wr_ok && hit_g_dat;
    wire wr_h_dat  = wr_ok && hit_h_dat;
    wire wr_f_dir  = wr_ok && hit_f_dir;
    wire wr_g_dir  = wr_ok && hit_g_dir;
    wire wr_h_dir  = wr_ok && hit_h_dir;
    wire wr_kbd    = wr_ok && hit_kbd;

    // Read taken and register decode, used by the checks below
    wire rd_take   = avs_read && take;
    wire mapped    = hit_f_dat | hit_g_dat | hit_h_dat | hit_f_dir | hit_g_dir
                     | hit_h_dir | hit_kbd;

    always_comb begin
        st_nxt = st_r;
        case (st_r)
            ST_IDLE: st_nxt = req ? ST_DONE : ST_IDLE;
            ST_DONE: st_nxt = ST_IDLE;
            default: st_nxt = ST_IDLE;
        endcase
    end

    assign avs_waitrequest = req && (st_r != ST_DONE);

    ////////////////////////////////////////////////////////////////////////
    // Ports
    logic [7:0] f_rd;
    logic [7:0] f_dir;
    logic [7:0] f_sync;
    logic [2:0] g_rd;
    logic [2:0] g_dir;
    logic [2:0] g_sync;
    logic [1:0] h_rd;
    logic [1:0] h_dir;
    logic [1:0] h_sync;
    logic [1:0] h_out_lat;
    logic [1:0] h_oe_lat;

    // Port F, eight pins
    gpfgh_port #(
        .W        (F_WIDTH),
        .DIR_RSTS (1'b1)
    ) u_f (
        .clk      (clk),
        .rst      (rst),
        .dat_we   (wr_f_dat),
        .dir_we   (wr_f_dir),
        .wdata    (wb[F_WIDTH-1:0]),
        .dat_rd   (f_rd),
        .dir_q    (f_dir),
        .pin_sync (f_sync),
        .pin_in   (f_pin_in),
        .pin_out  (f_pin_out),
        .pin_oe_n (f_pin_oe_n)
    );

    // Port G, three pins
    gpfgh_port #(
        .W        (G_WIDTH),
        .DIR_RSTS (1'b1)
    ) u_g (
        .clk      (clk),
        .rst      (rst),
        .dat_we   (wr_g_dat),
        .dir_we   (wr_g_dir),
        .wdata    (wb[G_WIDTH-1:0]),
        .dat_rd   (g_rd),
        .dir_q    (g_dir),
        .pin_sync (g_sync),
        .pin_in   (g_pin_in),
        .pin_out  (g_pin_out),
        .pin_oe_n (g_pin_oe_n)
    );

    gpfgh_port #(
        .W        (H_WIDTH),
        .DIR_RSTS (1'b1)
    ) u_h (
        .clk      (clk),
        .rst      (rst),
        .dat_we   (wr_h_dat),
        .dir_we   (wr_h_dir),
        .wdata    (wb[H_WIDTH-1:0]),
        .dat_rd   (h_rd),
        .dir_q    (h_dir),
        .pin_sync (h_sync),
        .pin_in   (h_pin_in),
        .pin_out  (h_out_lat),
        .pin_oe_n (h_oe_lat)
    );

    ////////////////////////////////////////////////////////////////////////
    // keypad enable takes pin as interrupt input
    always_ff @(posedge clk) begin
        if (rst) begin
            kbd_en_r <= KBD_EN_RST[1:0];
        end else if (wr_kbd) begin
            kbd_en_r <= wb[KBD_LO+1:KBD_LO];
        end
    end

    assign h_pin_out              = h_out_lat;
    assign h_pin_oe_n             = h_oe_lat | kbd_en_r;
    assign keypad_irq_pins        = h_sync & kbd_en_r;
    assign keypad_irq_enable_bits = kbd_en_r;

    ////////////////////////////////////////////////////////////////////////
    // Read data mux; unmapped reads return zero
    always_comb begin
        rdata_nxt = UNMAPPED_RD;
        if (hit_f_dat) begin
            rdata_nxt[7:0] = f_rd;
        end else if (hit_g_dat) begin
            rdata_nxt[2:0] = g_rd;
        end else if (hit_h_dat) begin
            rdata_nxt[1:0] = h_rd;
        end else if (hit_f_dir) begin
            rdata_nxt[7:0] = f_dir;
        end else if (hit_g_dir) begin
            rdata_nxt[2:0] = g_dir;
        end else if (hit_h_dir) begin
            rdata_nxt[1:0] = h_dir;
        end else if (hit_kbd) begin
            rdata_nxt[KBD_LO+1:KBD_LO] = kbd_en_r;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            st_r    <= ST_IDLE;
            rdata_r <= UNMAPPED_RD;
        end else begin
            st_r    <= st_nxt;
            rdata_r <= rdata_nxt;
        end
    end

    assign avs_readdata = rdata_r;

    ////////////////////////////////////////////////////////////////////////
    // Wait-cycle counter for the bus checks; saturates so it cannot wrap
    logic [1:0] wait_cnt_r;

    always_ff @(posedge clk) begin
        if (rst || !avs_waitrequest) begin
            wait_cnt_r <= 2'h0;
        end else if (wait_cnt_r != 2'h3) begin
            wait_cnt_r <= wait_cnt_r + 2'h1;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Bus checks
    // one wait cycle
    a_wait_one: assert property (@(posedge clk) disable iff (rst)
        (req && st_r == ST_IDLE) |-> avs_waitrequest ##1 !avs_waitrequest)
        else $error("bus answer not after one wait cycle");

    a_wait_bound: assert property (@(posedge clk) disable iff (rst)
        wait_cnt_r <= 2'h1)
        else $error("waitrequest held too long");

    a_idle_ready: assert property (@(posedge clk) disable iff (rst)
        !req |-> !avs_waitrequest)
        else $error("waitrequest raised without request");

    a_take_idle: assert property (@(posedge clk) disable iff (rst)
        take |=> st_r == ST_IDLE)
        else $error("bus state not idle after transfer");

    ////////////////////////////////////////////////////////////////////////
    // Reset checks
    // port G inputs
    a_g_reset: assert property (@(posedge clk) rst |=> g_pin_oe_n == 3'h7)
        else $error("port G not input after reset");

    a_h_reset: assert property (@(posedge clk) rst |=> h_pin_oe_n == 2'h3)
        else $error("port H not input after reset");

    a_f_reset: assert property (@(posedge clk) rst |=> f_pin_oe_n == 8'hFF)
        else $error("port F not input after reset");

    a_kbd_reset: assert property (@(posedge clk) rst |=> kbd_en_r == 2'h0)
        else $error("keypad enables not cleared by reset");

    ////////////////////////////////////////////////////////////////////////
    // Read data checks; read data were loaded one edge before the take
    // F input bits
    a_rd_f_pin: assert property (@(posedge clk) disable iff (rst)
        (rd_take && hit_f_dat)
        |-> ((avs_readdata[7:0] ^ $past(f_sync)) & ~$past(f_dir)) == 8'h00)
        else $error("port F input bit read wrong");

    a_rd_f_lat: assert property (@(posedge clk) disable iff (rst)
        (rd_take && hit_f_dat)
        |-> ((avs_readdata[7:0] ^ $past(f_pin_out)) & $past(f_dir)) == 8'h00)
        else $error("port F output bit read wrong");

    a_rd_g_pin: assert property (@(posedge clk) disable iff (rst)
        (rd_take && hit_g_dat)
        |-> ((avs_readdata[2:0] ^ $past(g_sync)) & ~$past(g_dir)) == 3'h0)
        else $error("port G input bit read wrong");

    a_rd_g_lat: assert property (@(posedge clk) disable iff (rst)
        (rd_take && hit_g_dat)
        |-> ((avs_readdata[2:0] ^ $past(g_pin_out)) & $past(g_dir)) == 3'h0)
        else $error("port G output bit read wrong");

    a_rd_h_pin: assert property (@(posedge clk) disable iff (rst)
        (rd_take && hit_h_dat)
        |-> ((avs_readdata[1:0] ^ $past(h_sync)) & ~$past(h_dir)) == 2'h0)
        else $error("port H input bit read wrong");

    a_rd_h_lat: assert property (@(posedge clk) disable iff (rst)
        (rd_take && hit_h_dat)
        |-> ((avs_readdata[1:0] ^ $past(h_out_lat)) & $past(h_dir)) == 2'h0)
        else $error("port H output bit read wrong");

    a_rd_g_upper: assert property (@(posedge clk) disable iff (rst)
        (rd_take && hit_g_dat) |-> avs_readdata[31:3] == 29'h0)
        else $error("port G read has upper bits set");

    a_rd_h_upper: assert property (@(posedge clk) disable iff (rst)
        (rd_take && hit_h_dat) |-> avs_readdata[31:2] == 30'h0)
        else $error("port H read has upper bits set");

    a_rd_unmapped: assert property (@(posedge clk) disable iff (rst)
        (rd_take && !mapped) |-> avs_readdata == UNMAPPED_RD)
        else $error("unmapped read not zero");

    a_rd_dir: assert property (@(posedge clk) disable iff (rst)
        (rd_take && (hit_f_dir || hit_g_dir || hit_h_dir))
        |-> avs_readdata[7:0] == (hit_f_dir ? $past(f_dir)
            : hit_g_dir ? {5'h00, $past(g_dir)} : {6'h00, $past(h_dir)}))
        else $error("direction readback wrong");

    ////////////////////////////////////////////////////////////////////////
    // Write and keypad checks
    // keypad enable write
    a_kbd_write: assert property (@(posedge clk) disable iff (rst)
        wr_kbd |=> kbd_en_r == $past(wb[KBD_LO+1:KBD_LO]))
        else $error("keypad enable write lost");

    a_wr_unmapped: assert property (@(posedge clk) disable iff (rst)
        (avs_write && take && !mapped)
        |=> $stable(f_dir) && $stable(g_dir) && $stable(h_dir) && $stable(kbd_en_r))
        else $error("unmapped write changed a register");

    a_kbd_nodrive: assert property (@(posedge clk) disable iff (rst)
        (kbd_en_r[0] |-> h_pin_oe_n[0]) and (kbd_en_r[1] |-> h_pin_oe_n[1]))
        else $error("interrupt pin driven");

    a_h_drive: assert property (@(posedge clk) disable iff (rst)
        (kbd_en_r == 2'h0) |-> h_pin_oe_n == ~h_dir)
        else $error("port H output enable does not follow direction");

    ////////////////////////////////////////////////////////////////////////
    // Scenario covers
    c_read_f: cover property (@(posedge clk) take && avs_read && hit_f_dat);
    c_write_h: cover property (@(posedge clk) wr_h_dat);
    c_kbd_on: cover property (@(posedge clk) kbd_en_r == 2'h3);
    c_mixed_f: cover property (@(posedge clk)
        rd_take && hit_f_dat && f_dir != 8'h00 && f_dir != 8'hFF);
    c_irq_pin: cover property (@(posedge clk) keypad_irq_pins != 2'h0);
endmodule // gpfgh_ports

// ==== sim/gpfgh_pin_model.sv ====
// Far-side pin model for one port.
// Assumes no pull resistors: an undriven pin shows the external level.
module gpfgh_pin_model #(
    parameter int W = 8
) (
    // Port side
    input  wire logic [W-1:0] pin_out,
    input  wire logic [W-1:0] pin_oe_n,
    // Far side
    input  wire logic [W-1:0] ext_level,
    output logic      [W-1:0] pin_level
);
    timeunit 1ns;
    timeprecision 1ps;
    assign pin_level = (pin_out & ~pin_oe_n) | (ext_level & pin_oe_n);
endmodule // gpfgh_pin_model

// ==== sim/gpfgh_ports_bench.sv ====
// Self-checking bench for ports F, G and H over Avalon-MM.
// Assumes one wait cycle per access and two-flop pin synchronisers.
`define CHK(nm, e, g) chk(nm, 32'(e), 32'(g))
module gpfgh_ports_bench;
    import gpfgh_pkg::*;
    timeunit 1ns;
    timeprecision 1ps;
    logic        clk, rst, wreq;
    gpfgh_req_s  req;
    logic [31:0] rdata;
    logic [7:0]  f_out, f_oe_n, f_ext, f_lvl;
    logic [2:0]  g_out, g_oe_n, g_ext, g_lvl;
    logic [1:0]  h_out, h_oe_n, h_ext, h_lvl, kb_pins, kb_en;
    int          bad_count, total_checks;
    ////////////////////////////////////////////////////////////////////////
    gpfgh_ports uut (.clk(clk), .rst(rst), .avs_address(req.address),
        .avs_read(req.read), .avs_write(req.write), .avs_byteenable(req.byteenable),
        .avs_writedata(req.writedata), .avs_readdata(rdata), .avs_waitrequest(wreq),
        .f_pin_in(f_lvl), .f_pin_out(f_out), .f_pin_oe_n(f_oe_n),
        .g_pin_in(g_lvl), .g_pin_out(g_out), .g_pin_oe_n(g_oe_n),
        .h_pin_in(h_lvl), .h_pin_out(h_out), .h_pin_oe_n(h_oe_n),
        .keypad_irq_pins(kb_pins), .keypad_irq_enable_bits(kb_en));
    gpfgh_pin_model #(.W(8)) m_f (.pin_out(f_out), .pin_oe_n(f_oe_n),
        .ext_level(f_ext), .pin_level(f_lvl));
    gpfgh_pin_model #(.W(3)) m_g (.pin_out(g_out), .pin_oe_n(g_oe_n),
        .ext_level(g_ext), .pin_level(g_lvl));
    gpfgh_pin_model #(.W(2)) m_h (.pin_out(h_out), .pin_oe_n(h_oe_n),
        .ext_level(h_ext), .pin_level(h_lvl));
    ////////////////////////////////////////////////////////////////////////
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        total_checks++;
        if (g !== e) begin
            bad_count++;
            $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
        end
    endtask
    // Request held until waitrequest is seen low at a rising edge
    task automatic bus(input logic w, input logic [7:0] idx, input logic [7:0] d,
                       output logic [31:0] q);
        int n;
        q = '0;
        @(posedge clk);
        req <= '{address: {idx, 2'b00}, read: !w, write: w, byteenable: 4'hF,
                 writedata: {24'h0, d}};
        for (n = 0; n < 20; n++) begin
            @(posedge clk);
            if (wreq === 1'b0) begin
                q = rdata;
                break;
            end
        end
        if (n == 20) begin
            bad_count++;
            give_verdict();
        end
        req <= '0;
    endtask
    task automatic wr(input logic [7:0] idx, input logic [7:0] d);
        logic [31:0] q;
        bus(1'b1, idx, d, q);
    endtask
    task automatic rd(input string nm, input logic [7:0] idx, input logic [31:0] e);
        logic [31:0] q;
        bus(1'b0, idx, 8'h00, q);
        `CHK(nm, e, q);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    initial begin
        rst = 1'b1;
        req = '0;
        f_ext = 8'hA5;
        g_ext = 3'h5;
        h_ext = 2'h2;
        bad_count = 0;
        total_checks = 0;
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        rd("f_dir", IDX_F_DIR, 32'h0);
        rd("g_dir", IDX_G_DIR, 32'h0);
        rd("h_dir", IDX_H_DIR, 32'h0);
        `CHK("oe_n", 13'h1FFF, {f_oe_n, g_oe_n, h_oe_n});
        $display("test reset done");
        rd("f_in", IDX_F_DATA, 32'hA5);
        rd("g_in", IDX_G_DATA, 32'h5);
        rd("h_in", IDX_H_DATA, 32'h2);
        f_ext <= 8'h5A;
        repeat (3) @(posedge clk);
        rd("f_sync", IDX_F_DATA, 32'h5A);
        $display("test input reads done");
        // Latch loaded before direction change
        wr(IDX_F_DATA, 8'h3C);
        rd("f_keep", IDX_F_DATA, 32'h5A);
        `CHK("f_out", 8'h3C, f_out);
        wr(IDX_F_DIR, 8'hF0);
        rd("f_mix", IDX_F_DATA, 32'h3A);
        `CHK("f_oe", 8'h0F, f_oe_n);
        `CHK("f_lvl", 8'h3A, f_lvl);
        wr(IDX_F_DATA, 8'hC3);
        rd("f_out_wr", IDX_F_DATA, 32'hCA);
        wr(IDX_G_DATA, 8'h02);
        wr(IDX_G_DIR, 8'h03);
        rd("g_mix", IDX_G_DATA, 32'h6);
        `CHK("g_oe", 3'h4, g_oe_n);
        `CHK("g_out", 3'h2, g_out);
        wr(IDX_H_DATA, 8'h01);
        wr(IDX_H_DIR, 8'h01);
        rd("h_mix", IDX_H_DATA, 32'h3);
        $display("test output mix done");
        @(posedge clk);
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        rd("g_dir2", IDX_G_DIR, 32'h0);
        rd("h_dir2", IDX_H_DIR, 32'h0);
        wr(IDX_H_DIR, 8'h03);
        rd("h_hold", IDX_H_DATA, 32'h1);
        `CHK("h_lvl", 2'h1, h_lvl);
        $display("test second reset done");
        wr(IDX_KBD_EN, 8'h18);
        rd("kbd_en", IDX_KBD_EN, 32'h18);
        `CHK("kb_en", 2'h3, kb_en);
        `CHK("h_oe_kb", 2'h3, h_oe_n);
        `CHK("kb_pins", 2'h2, kb_pins);
        $display("test keypad done");
        wr(8'h20, 8'hFF);
        rd("unmapped", 8'h20, 32'h0);
        $display("test unmapped done");
        give_verdict();
    end
endmodule // gpfgh_ports_bench
